// ===== pkg/lpm_regs_pkg.sv
// Shared constants and types for the low-power and analog mux command registers
package lpm_regs_pkg;

  // Serial frame layout
  localparam int FRAME_W = 32;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 24;
  localparam int FRAME_ADDR_MSB = 31;
  localparam int FRAME_ADDR_LSB = 25;
  localparam int FRAME_RW_BIT = 24;
  localparam logic RW_WRITE = 1'b1;
  localparam logic [5:0] FRAME_COUNT_FULL = 6'h20;
  localparam logic [5:0] FRAME_COUNT_OVER = 6'h21;

  // Reply word layout
  localparam int REPLY_FAULT_BIT = 23;
  localparam int REPLY_INT_BIT = 22;
  localparam int STATUS_W = 22;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_DEBOUNCE = 7'h1B;
  localparam logic [ADDR_W-1:0] ADDR_LPM_ENTRY = 7'h1C;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_OUTPUT_MUX = 7'h1D;

  // Field layouts and reset values
  localparam int GROUND_INPUTS = 14;
  localparam int ANALOG_OUTPUT_MUX_CURRENT_BIT = 6;
  localparam int CHAN_W = 6;
  localparam logic [GROUND_INPUTS-1:0] DEBOUNCE_RESET = 14'h0000;
  localparam logic ANALOG_OUTPUT_MUX_CURRENT_RESET = 1'b0;
  localparam logic [DATA_W-1:0] LPM_ENTRY_DATA = 24'h000000;

  // Analog channel codes
  localparam int ANALOG_OUTPUT_MUX_SOURCES = 24;
  localparam logic [CHAN_W-1:0] CHAN_NONE = 6'h00;
  localparam logic [CHAN_W-1:0] CHAN_FIRST = 6'h01;
  localparam logic [CHAN_W-1:0] CHAN_INPUT_LAST = 6'h16;
  localparam logic [CHAN_W-1:0] CHAN_BATTERY = 6'h18;

  // Timing
  localparam real DEBOUNCE_EXTEND_MS = 1.2;
  localparam real SYS_CLK_MHZ = 100.0;
  localparam int DEBOUNCE_EXTEND_CYCLES = int'(DEBOUNCE_EXTEND_MS * 1000.0 * SYS_CLK_MHZ);

  typedef enum logic {MODE_NORMAL, MODE_LOW_POWER} power_mode_t;

endpackage

// ===== logic/spi_frame_rx.sv
// Serial clock domain frame receiver: shifts in one framed command word
`timescale 1ns/1ns
`default_nettype none

module spi_frame_rx (
  // Reset
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  // Towards the system clock domain
  output logic [lpm_regs_pkg::FRAME_W-1:0] frame_word,
  output logic frame_full,
  output logic frame_over,
  output logic bit_toggle
);
  import lpm_regs_pkg::*;

  typedef struct packed {
    logic [FRAME_W-1:0] shift;
    logic [5:0] count;
    logic full;
    logic over;
    logic toggle;
  } link_t;

  link_t st;
  link_t next_st;
  logic link_clear;

  ////////////////////////////////////////////////////////////////////////////////
  // The serial clock stops between frames, so a raised chip select clears the
  // frame state without needing an edge.
  assign link_clear = reset | cs_b;

  always_comb begin
    next_st = st;
    next_st.shift = {st.shift[FRAME_W-2:0], mosi};
    next_st.toggle = ~st.toggle;
    if (st.count != FRAME_COUNT_OVER) begin
      next_st.count = st.count + 6'h01;
    end
    next_st.full = (next_st.count == FRAME_COUNT_FULL); // see [RULE_17]
    next_st.over = (next_st.count == FRAME_COUNT_OVER);
  end

  always_ff @(posedge sclk or posedge link_clear) begin
    if (link_clear) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign frame_word = st.shift;
  assign frame_full = st.full;
  assign frame_over = st.over;
  assign bit_toggle = st.toggle;

endmodule

`default_nettype wire

// ===== logic/lpm_debounce_analog_output_mux_regs.sv
// Command registers: wake debounce enables, low-power entry and analog mux control
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// [RULE_01] Debounce bit clear: voltage-difference wake decision
// [RULE_02] Debounce bit set: hold polling current 1.2 ms
// [RULE_03] Ground debounce register 0x1B, 14 bits, zero
// [RULE_04] Low-power entry only by dedicated command
// [RULE_05] Settings survive low-power entry and wake
// [RULE_06] Write-only entry register starts low-power polling
// [RULE_07] First reply after wake forces both flags
// [RULE_08] Host sends entry command with zero data
// [RULE_09] One analog mux, 24 sources, one selected
// [RULE_10] Selected analog input reads zero in status
// [RULE_11] Analog select rewritable anytime in normal mode
// [RULE_12] Analog select resets to no input
// [RULE_13] Analog register 0x1D: current bit, channel field
// [RULE_14] Current bit: 0 high impedance, 1 wetting
// [RULE_15] Channel codes: none, ground, programmable, monitors
// [RULE_16] Replies carry fault bit 23, interrupt 22
// [RULE_17] Frame: chip select falls, then 32 clocks
// [RULE_18] Codes above 24 select nothing; unused zero
// [RULE_19] Writes commit only after complete closed frame
////////////////////////////////////////////////////////////////////////////////

module lpm_debounce_analog_output_mux_regs #(
  parameter int EXTEND_CYCLES = lpm_regs_pkg::DEBOUNCE_EXTEND_CYCLES
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Switch sensing, system clock domain
  input wire logic [lpm_regs_pkg::STATUS_W-1:0] switch_status,
  input wire logic fault_summary,
  input wire logic interrupt_flag,
  input wire logic wake_event,
  input wire logic poll_strobe,
  // Low-power control
  output logic low_power_mode,
  output logic [lpm_regs_pkg::GROUND_INPUTS-1:0] debounce_enable,
  output logic poll_extend,
  output logic sample_final,
  // Analog mux
  output logic [lpm_regs_pkg::CHAN_W-1:0] analog_output_mux_channel,
  output logic [lpm_regs_pkg::ANALOG_OUTPUT_MUX_SOURCES-1:0] analog_output_mux_select,
  output logic analog_current_source_select
);
  import lpm_regs_pkg::*;

  localparam int EXT_W = $clog2(EXTEND_CYCLES + 1);
  localparam logic [EXT_W-1:0] EXT_LOAD = EXT_W'(EXTEND_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [CHAN_W-1:0] clean_channel(input logic [CHAN_W-1:0] code);
    if (code > CHAN_BATTERY) begin
      clean_channel = CHAN_NONE;
    end else begin
      clean_channel = code;
    end
  endfunction

  function automatic logic [ANALOG_OUTPUT_MUX_SOURCES-1:0] channel_onehot(input logic [CHAN_W-1:0] code);
    logic [CHAN_W-1:0] clean;
    clean = clean_channel(code);
    if (clean == CHAN_NONE) begin
      channel_onehot = '0;
    end else begin
      channel_onehot = ANALOG_OUTPUT_MUX_SOURCES'(1) << (clean - CHAN_FIRST);
    end
  endfunction

  // Switch inputs share the status bit order with the channel codes, offset by one
  function automatic logic [STATUS_W-1:0] analog_mask(input logic [CHAN_W-1:0] code);
    analog_mask = '0;
    if (code >= CHAN_FIRST && code <= CHAN_INPUT_LAST) begin
      analog_mask = STATUS_W'(1) << (code - CHAN_FIRST);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic full_meta;
    logic full_sync;
    logic full_prev;
    logic over_meta;
    logic over_sync;
    logic tick_meta;
    logic tick_sync;
    logic tick_prev;
    logic [FRAME_W-1:0] rx_word;
    logic frame_ok;
    logic [GROUND_INPUTS-1:0] debounce;
    logic current_sel;
    logic [CHAN_W-1:0] chan;
    logic [ANALOG_OUTPUT_MUX_SOURCES-1:0] mux_onehot;
    power_mode_t mode;
    logic wake_reply;
    logic [ADDR_W-1:0] last_addr;
    logic last_rw;
    logic [FRAME_W-1:0] reply;
    logic miso_bit;
    logic miso_oe_n;
    logic [EXT_W-1:0] ext_count;
    logic poll_extend;
    logic sample_final;
  } sys_t;

  sys_t st;
  sys_t next_st;

  logic [FRAME_W-1:0] link_word;
  logic link_full;
  logic link_over;
  logic link_toggle;

  logic cs_fall;
  logic cs_rise;
  logic full_rise;
  logic tick;
  logic wake_now;
  logic commit;
  logic [ADDR_W-1:0] cmd_addr;
  logic cmd_rw;
  logic [DATA_W-1:0] cmd_data;
  logic cmd_write_normal;
  logic [STATUS_W-1:0] reply_data;
  logic reply_forced;
  logic [FRAME_W-1:0] reply_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock domain

  spi_frame_rx u_frame_rx (
    .reset(reset),
    .sclk(sclk),
    .cs_b(cs_b),
    .mosi(mosi),
    .frame_word(link_word),
    .frame_full(link_full),
    .frame_over(link_over),
    .bit_toggle(link_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing events and command decode

  assign cs_fall = st.cs_prev & ~st.cs_sync;
  assign cs_rise = ~st.cs_prev & st.cs_sync;
  assign full_rise = st.full_sync & ~st.full_prev;
  assign tick = st.tick_sync ^ st.tick_prev;

  assign cmd_addr = st.rx_word[FRAME_ADDR_MSB:FRAME_ADDR_LSB];
  assign cmd_rw = st.rx_word[FRAME_RW_BIT];
  assign cmd_data = st.rx_word[DATA_W-1:0];

  // A frame counts only if exactly 32 clocks arrived before chip select rose
  assign commit = cs_rise & st.frame_ok & ~st.over_sync; // see [RULE_19]
  assign cmd_write_normal = commit & (cmd_rw == RW_WRITE) & (st.mode == MODE_NORMAL);

  // Any chip select fall or external wake source ends low-power mode
  assign wake_now = (st.mode == MODE_LOW_POWER) & (wake_event | cs_fall);

  ////////////////////////////////////////////////////////////////////////////////
  // Reply word, loaded at the start of each frame

  always_comb begin
    reply_data = switch_status & ~analog_mask(st.chan); // see [RULE_10]
    if (!st.last_rw) begin
      case (st.last_addr)
        ADDR_DEBOUNCE: begin
          reply_data = STATUS_W'(st.debounce); // see [RULE_03]
        end
        ADDR_ANALOG_OUTPUT_MUX: begin
          reply_data = STATUS_W'({st.current_sel, st.chan}); // see [RULE_18]
        end
        default: begin
          reply_data = switch_status & ~analog_mask(st.chan);
        end
      endcase
    end
  end

  assign reply_forced = st.wake_reply | wake_now;

  always_comb begin
    reply_word = '0;
    reply_word[STATUS_W-1:0] = reply_data;
    reply_word[REPLY_FAULT_BIT] = fault_summary | reply_forced; // see [RULE_16]
    reply_word[REPLY_INT_BIT] = interrupt_flag | reply_forced; // see [RULE_07]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;

    // Two-stage synchronisers; the first stage feeds only the second
    next_st.cs_meta = cs_b;
    next_st.cs_sync = st.cs_meta;
    next_st.cs_prev = st.cs_sync;
    next_st.full_meta = link_full;
    next_st.full_sync = st.full_meta;
    next_st.full_prev = st.full_sync;
    next_st.over_meta = link_over;
    next_st.over_sync = st.over_meta;
    next_st.tick_meta = link_toggle;
    next_st.tick_sync = st.tick_meta;
    next_st.tick_prev = st.tick_sync;
    next_st.sample_final = 1'b0;

    // The link word is held steady from the full flag until the next clock edge,
    // which limits the serial clock period to well over four system cycles.
    if (full_rise && !st.cs_sync) begin
      next_st.rx_word = link_word;
      next_st.frame_ok = 1'b1;
    end
    if (st.over_sync || cs_fall) begin
      next_st.frame_ok = 1'b0; // see [RULE_19]
    end

    // Wake from low-power mode keeps every programmed setting
    if (wake_now) begin
      next_st.mode = MODE_NORMAL; // see [RULE_05]
      next_st.wake_reply = 1'b1;
    end

    // Register writes
    if (cmd_write_normal) begin
      case (cmd_addr)
        ADDR_DEBOUNCE: begin
          next_st.debounce = cmd_data[GROUND_INPUTS-1:0]; // see [RULE_03]
        end
        ADDR_ANALOG_OUTPUT_MUX: begin
          next_st.current_sel = cmd_data[ANALOG_OUTPUT_MUX_CURRENT_BIT]; // see [RULE_13]
          next_st.chan = clean_channel(cmd_data[CHAN_W-1:0]); // see [RULE_11]
          next_st.mux_onehot = channel_onehot(cmd_data[CHAN_W-1:0]); // see [RULE_15]
        end
        ADDR_LPM_ENTRY: begin
          // Nonzero data is not the entry command and is dropped
          if (cmd_data == LPM_ENTRY_DATA) begin
            next_st.mode = MODE_LOW_POWER; // see [RULE_04]
          end
        end
        default: begin
          next_st.mode = st.mode;
        end
      endcase
    end
    if (commit) begin
      next_st.last_addr = cmd_addr;
      next_st.last_rw = cmd_rw;
    end

    // Reply shifting: bit 31 sits on the line before the first clock
    if (cs_fall) begin
      next_st.reply = reply_word;
      next_st.miso_bit = reply_word[FRAME_W-1];
      next_st.miso_oe_n = 1'b0;
      next_st.wake_reply = 1'b0; // see [RULE_07]
    end else if (tick && !st.cs_sync) begin
      next_st.reply = {st.reply[FRAME_W-2:0], 1'b0};
      next_st.miso_bit = st.reply[FRAME_W-2];
    end
    if (cs_rise) begin
      next_st.miso_oe_n = 1'b1;
      next_st.miso_bit = 1'b0;
    end

    // Debounce extension: inputs with a set bit keep the polling current on
    // and are judged on the final level; clear bits use the difference method.
    if (st.poll_extend) begin
      if (st.mode != MODE_LOW_POWER) begin
        next_st.poll_extend = 1'b0;
      end else if (st.ext_count == '0) begin
        next_st.poll_extend = 1'b0;
        next_st.sample_final = 1'b1; // see [RULE_02]
      end else begin
        next_st.ext_count = st.ext_count - EXT_W'(1);
      end
    end else if (st.mode == MODE_LOW_POWER && poll_strobe && |st.debounce) begin
      next_st.poll_extend = 1'b1; // see [RULE_06]
      next_st.ext_count = EXT_LOAD; // see [RULE_02]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.cs_meta <= 1'b1;
      st.cs_sync <= 1'b1;
      st.cs_prev <= 1'b1;
      st.debounce <= DEBOUNCE_RESET; // see [RULE_03]
      st.current_sel <= ANALOG_OUTPUT_MUX_CURRENT_RESET; // see [RULE_14]
      st.chan <= CHAN_NONE; // see [RULE_12]
      st.mode <= MODE_NORMAL;
      st.last_rw <= RW_WRITE;
      st.miso_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign miso = st.miso_bit;
  assign miso_oe_n = st.miso_oe_n;
  assign low_power_mode = (st.mode == MODE_LOW_POWER); // see [RULE_06]
  assign debounce_enable = st.debounce; // see [RULE_01]
  assign poll_extend = st.poll_extend;
  assign sample_final = st.sample_final;
  assign analog_output_mux_channel = st.chan;
  assign analog_output_mux_select = st.mux_onehot; // see [RULE_09]
  assign analog_current_source_select = st.current_sel; // see [RULE_14]

endmodule

`default_nettype wire

// ===== sim/spi_host_model.sv
// Host side serial master model that sends one framed command word at a time
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
  // Serial link
  output logic sclk,
  output logic cs_b,
  output logic mosi,
  input wire logic miso
);
  logic [31:0] rx;
  event done;

  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Any nbits but 32 makes a broken frame; only whole frames announce a reply
  task automatic xfer(input logic [31:0] w, input int nbits, output logic [31:0] r);
    #7;
    cs_b = 1'b0;
    #80;
    for (int i = 31; i > 31 - nbits; i--) begin
      mosi = (i >= 0) ? w[i] : 1'b0;
      #80;
      sclk = 1'b1;
      if (i >= 0) r[i] = miso;
      #80;
      sclk = 1'b0;
    end
    #80;
    cs_b = 1'b1;
    // Released data line must not keep showing the last bit
    mosi = ~mosi;
    rx = r;
    if (nbits == 32) begin
      ->done;
    end
    #100;
  endtask
endmodule

`default_nettype wire

// ===== sim/lpm_regs_sva.sv
// Concurrent checks on the command register block ports
`timescale 1ns/1ns
`default_nettype none

module lpm_regs_sva #(
  parameter int EXTEND_CYCLES = lpm_regs_pkg::DEBOUNCE_EXTEND_CYCLES
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  // Serial link
  input wire logic cs_b,
  input wire logic miso,
  input wire logic miso_oe_n,
  // Low-power control
  input wire logic wake_event,
  input wire logic poll_strobe,
  input wire logic low_power_mode,
  input wire logic [lpm_regs_pkg::GROUND_INPUTS-1:0] debounce_enable,
  input wire logic poll_extend,
  input wire logic sample_final,
  // Analog mux
  input wire logic [lpm_regs_pkg::CHAN_W-1:0] analog_output_mux_channel,
  input wire logic [lpm_regs_pkg::ANALOG_OUTPUT_MUX_SOURCES-1:0] analog_output_mux_select,
  input wire logic analog_current_source_select
);
  import lpm_regs_pkg::*;
  int ext_cnt;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Length of the current extension run
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ext_cnt <= 0;
    end else begin
      ext_cnt <= poll_extend ? ext_cnt + 1 : 0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Six samples allow for the 3 to 4 cycle crossing delay
  sequence cs_idle_s;
    cs_b [*6];
  endsequence
  sequence cs_open_s;
    !cs_b [*6];
  endsequence
  sequence strobe_hit_s;
    low_power_mode && poll_strobe && !wake_event && !poll_extend;
  endsequence

  AST_IDLE_QUIET: assert property (cs_idle_s |-> miso_oe_n && !miso)
    else $error("miso driven while idle");
  AST_NO_COMMIT_OPEN: assert property (cs_open_s |->
    $stable(analog_output_mux_channel) && $stable(debounce_enable))
    else $error("register changed inside frame");
  AST_ONE_HOT: assert property (analog_output_mux_channel != 0 |->
    analog_output_mux_select == 24'h000001 << (analog_output_mux_channel - 1))
    else $error("mux select does not match channel");
  AST_NONE_SEL: assert property (analog_output_mux_channel == 0 |->
    analog_output_mux_select == 24'h000000)
    else $error("mux select without channel");
  AST_CHAN_MAX: assert property (analog_output_mux_channel <= 6'h18)
    else $error("stored channel out of range");
  AST_LPM_ONLY: assert property ($rose(low_power_mode) |-> cs_b && $past(cs_b, 2))
    else $error("low power entered without closed frame");
  AST_EXT_START: assert property (strobe_hit_s ##0
    debounce_enable != 0 |=> poll_extend)
    else $error("extension did not start");
  AST_EXT_NONE: assert property (poll_strobe && debounce_enable == 0 &&
    !poll_extend |=> !poll_extend)
    else $error("extension without debounce bit");
  AST_EXT_LEN: assert property (sample_final |->
    ext_cnt == EXTEND_CYCLES && !poll_extend)
    else $error("extension length wrong");
  AST_HOLD_LPM: assert property (low_power_mode |=>
    $stable(debounce_enable) && $stable(analog_output_mux_channel))
    else $error("settings changed in low power");
endmodule

bind lpm_debounce_analog_output_mux_regs lpm_regs_sva #(.EXTEND_CYCLES(EXTEND_CYCLES)) u_sva (
  .sys_clk, .reset, .cs_b, .miso, .miso_oe_n, .wake_event, .poll_strobe, .low_power_mode,
  .debounce_enable, .poll_extend, .sample_final, .analog_output_mux_channel, .analog_output_mux_select,
  .analog_current_source_select
);

`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the command register block
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e, m) \
  begin \
    n_compared++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("BAD %0t %s", $time, m); \
    end \
  end

module testbench;
  import lpm_regs_pkg::*;
  localparam int EXT = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic sclk, cs_b, mosi, miso, miso_oe_n;
  logic [STATUS_W-1:0] switch_status = '0;
  logic fault_summary = 1'b0;
  logic interrupt_flag = 1'b0;
  logic wake_event = 1'b0;
  logic poll_strobe = 1'b0;
  logic low_power_mode, poll_extend, sample_final, analog_current_source_select;
  logic [GROUND_INPUTS-1:0] debounce_enable;
  logic [CHAN_W-1:0] analog_output_mux_channel;
  logic [ANALOG_OUTPUT_MUX_SOURCES-1:0] analog_output_mux_select;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 95339;
  int rnd, n, i;
  logic [31:0] junk;
  logic [31:0] exp_q[$];
  // Reference copy of the registers and of the previous command
  logic [13:0] m_deb = '0;
  logic m_cur = 1'b0;
  logic [5:0] m_chan = '0;
  logic [6:0] m_prev = '0;
  logic m_prev_rd = 1'b0;
  logic m_woke = 1'b0;

  always #5 sys_clk = ~sys_clk;

  lpm_debounce_analog_output_mux_regs #(.EXTEND_CYCLES(EXT)) DUT (
    .sys_clk, .reset, .sclk, .cs_b, .mosi, .miso, .miso_oe_n, .switch_status, .fault_summary,
    .interrupt_flag, .wake_event, .poll_strobe, .low_power_mode, .debounce_enable, .poll_extend,
    .sample_final, .analog_output_mux_channel, .analog_output_mux_select, .analog_current_source_select
  );
  spi_host_model host (.sclk, .cs_b, .mosi, .miso);

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] expect_reply();
    logic [21:0] d;
    d = switch_status;
    if (m_chan >= 1 && m_chan <= 22) d[m_chan - 1] = 1'b0;
    if (m_prev_rd && m_prev == ADDR_DEBOUNCE) d = {8'h00, m_deb};
    if (m_prev_rd && m_prev == ADDR_ANALOG_OUTPUT_MUX) d = {15'h0000, m_cur, m_chan};
    return {8'h00, fault_summary | m_woke, interrupt_flag | m_woke, d};
  endfunction

  task automatic frame(input logic [31:0] w);
    int r;
    logic [31:0] back;
    @(posedge sys_clk);
    r = $random(seed);
    switch_status <= r[21:0];
    fault_summary <= r[31];
    interrupt_flag <= r[30];
    @(posedge sys_clk);
    exp_q.push_back(expect_reply());
    host.xfer(w, 32, back);
    m_woke = 1'b0;
    m_prev = w[31:25];
    m_prev_rd = !w[24];
    if (w[24] && w[31:25] == ADDR_DEBOUNCE) m_deb = w[13:0];
    if (w[24] && w[31:25] == ADDR_ANALOG_OUTPUT_MUX) begin
      m_cur = w[6];
      m_chan = (w[5:0] > 6'h18) ? 6'h00 : w[5:0];
    end
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(host.done) begin
    `CHK(host.rx, exp_q.pop_front(), "reply word")
  end

  initial begin
    #900000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK({miso_oe_n, low_power_mode, miso}, 3'b100, "reset link")
    `CHK({debounce_enable, analog_output_mux_channel}, 20'h00000, "reset regs")
    `CHK({analog_output_mux_select, analog_current_source_select}, 25'h0, "reset mux")
    `CHK({poll_extend, sample_final}, 2'b00, "reset poll")
    rnd = $random(seed);
    frame({ADDR_DEBOUNCE, RW_WRITE, rnd[23:0]});
    `CHK(debounce_enable, rnd[13:0], "debounce")
    frame({ADDR_DEBOUNCE, 25'h0000000});
    frame({7'h1F, 25'h0000000});
    $display("test debounce done");
    for (int c = 0; c < 27; c++) begin
      rnd = $random(seed);
      frame({ADDR_ANALOG_OUTPUT_MUX, RW_WRITE, rnd[23:6], c[5:0]});
      `CHK(analog_output_mux_channel, (c > 24) ? 6'h00 : c[5:0], "channel")
      `CHK(analog_output_mux_select, 24'(m_chan != 0) << (m_chan - 1), "sel")
      `CHK(analog_current_source_select, rnd[6], "current")
    end
    frame({ADDR_ANALOG_OUTPUT_MUX, 25'h0000000});
    frame({ADDR_ANALOG_OUTPUT_MUX, RW_WRITE, 24'h000005});
    // One clock short, then one clock too many
    for (int b = 31; b < 34; b += 2) begin
      host.xfer({ADDR_ANALOG_OUTPUT_MUX, RW_WRITE, 24'h000047}, b, junk);
      repeat (8) @(posedge sys_clk);
      `CHK(analog_output_mux_channel, 6'h05, "cut frame")
    end
    $display("test analog mux done");
    frame({ADDR_LPM_ENTRY, RW_WRITE, 24'h000100});
    `CHK(low_power_mode, 1'b0, "entry with data")
    for (int k = 0; k < 2; k++) begin
      frame({ADDR_DEBOUNCE, RW_WRITE, k ? 24'h002001 : 24'h000000});
      frame({ADDR_LPM_ENTRY, RW_WRITE, LPM_ENTRY_DATA});
      `CHK(low_power_mode, 1'b1, "entry")
      poll_strobe <= 1'b1;
      @(posedge sys_clk);
      poll_strobe <= 1'b0;
      n = 0;
      for (i = 0; i < 100 && sample_final !== 1'b1; i++) begin
        @(negedge sys_clk);
        n += (poll_extend === 1'b1);
      end
      `CHK(n, k ? EXT : 0, "extension length")
      `CHK(i < 100, k == 1, "final sample")
      if (k) begin
        @(posedge sys_clk);
        wake_event <= 1'b1;
        @(posedge sys_clk);
        wake_event <= 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(low_power_mode, 1'b0, "wake")
      end
      m_woke = 1'b1;
      frame({7'h1F, 25'h0000000});
      `CHK({low_power_mode, analog_output_mux_channel}, 7'h05, "kept channel")
      `CHK(debounce_enable, m_deb, "kept debounce")
    end
    $display("test low power done");
    // Second reset in mid-run, with settings programmed
    reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    m_deb = '0;
    m_cur = 1'b0;
    m_chan = '0;
    m_prev_rd = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK({miso_oe_n, low_power_mode, miso}, 3'b100, "mid reset link")
    `CHK({debounce_enable, analog_output_mux_channel}, 20'h00000, "mid reset regs")
    `CHK(analog_output_mux_select, 24'h000000, "mid reset mux")
    frame({ADDR_ANALOG_OUTPUT_MUX, 25'h0000000});
    frame({7'h1F, 25'h0000000});
    $display("test reset done");
    conclude();
  end
endmodule

`default_nettype wire
